// *** hpp_pwm.sv ***
// The implementer's own choices: the register addresses and the strobed register port.
module hpp_pwm (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire hpp_pkg::hpp_addr_t reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [hpp_pkg::DUTY_W-1:0] duty_in,
    input wire logic duty_valid,
    input wire logic sync_in,
    input wire logic fault_in,
    output logic sync_out,
    output logic phase_trig,
    output logic adc_trig,
    output logic period_evt,
    output logic pwm_a,
    output logic pwm_b,
    output logic [hpp_pkg::FINE_W-1:0] fine_a,
    output logic [hpp_pkg::FINE_W-1:0] fine_b,
    output logic blank_a,
    output logic blank_b,
    output logic fault_out
);
    import hpp_pkg::*;

    typedef struct packed {
        hpp_cfg_t sh;
        hpp_cfg_t ac;
        logic [22:0] duty_sh;
        logic [22:0] duty_ac;
        logic [13:0] cnt;
        logic [13:0] seg;
        logic [31:0] rdata;
        logic sync_out;
        logic phase_trig;
        logic adc_trig;
        logic period_evt;
        logic blank_a;
        logic blank_b;
        logic fault_out;
    } hpp_state_t;

    hpp_state_t q, d;

    logic on_a, on_b;
    logic [18:0] a_rise, a_fall, b_rise, b_fall;
    logic [18:0] duty_fine;
    logic [37:0] duty_prod;
    logic [14:0] seg_len;
    logic wrap, sync_hit, samp_hit1, samp_hit2;

    // adjust, clamp and trim a fine position to the selected step size
    function automatic logic [18:0] place(input logic [19:0] base,
                                          input logic [15:0] adj,
                                          input hpp_ctrl_t c);
        logic signed [21:0] s;
        logic [18:0] r;
        s = $signed({2'b00, base}) + $signed({{6{adj[15]}}, adj});
        if (s < 22'sd0) begin
            r = '0;
        end else if (s > 22'sh7ffff) begin
            r = 19'h7ffff;
        end else begin
            r = s[18:0];
        end
        // off or phase clocks stopped: whole 4 ns steps only
        if (!c.fine_multi_output_enable || !c.phase_clocks_enable) begin
            r[3:0] = 4'h0;
        end else begin
            r[3:0] = r[3:0] & (4'hf << c.fine_step_scale);
        end
        place = r;
    endfunction : place

    function automatic logic inside_win(input logic [13:0] c, input logic [13:0] b,
                                        input logic [13:0] e);
        inside_win = (c >= b) && (c < e);
    endfunction : inside_win

    function automatic logic [31:0] rd_mux(input hpp_cfg_t s, input hpp_addr_t a,
                                           input logic [13:0] c, input logic pa,
                                           input logic pb);
        case (a)
            A_CTRL: rd_mux = {20'h0, s.ctrl};
            A_PERIOD: rd_mux = {18'h0, s.period_limit};
            A_EV1: rd_mux = {18'h0, s.ev1};
            A_EV2: rd_mux = {14'h0, s.ev2};
            A_EV3: rd_mux = {14'h0, s.ev3};
            A_EV4: rd_mux = {14'h0, s.ev4};
            A_ADJ_A: rd_mux = {16'h0, s.adj_a};
            A_ADJ_B: rd_mux = {16'h0, s.adj_b};
            A_SAMP1: rd_mux = {18'h0, s.samp1};
            A_SAMP2: rd_mux = {18'h0, s.samp2};
            A_PHASE: rd_mux = {18'h0, s.phase};
            A_SYNC: rd_mux = {18'h0, s.sync_thr};
            A_BLANK_A: rd_mux = {2'h0, s.blka_end, 2'h0, s.blka_beg};
            A_BLANK_B: rd_mux = {2'h0, s.blkb_end, 2'h0, s.blkb_beg};
            A_DEAD: rd_mux = {24'h0, s.dead};
            A_STATUS: rd_mux = {16'h0, pb, pa, c};
            default: rd_mux = 32'h0;
        endcase
    endfunction : rd_mux

    // negative duty reads as zero; full scale maps to the whole period in fine steps
    always_comb begin
        duty_prod = {15'h0, q.duty_ac} * {23'h0, ({1'b0, q.ac.period_limit} + 15'h1)};
        duty_fine = duty_prod[37:19];
    end

    // edge positions; fine bits are carried only on events two to four
    always_comb begin
        a_rise = {1'b0, q.ac.ev1, 4'h0};
        b_rise = place({2'b00, q.ac.ev3}, 16'h0, q.ac.ctrl);
        if (q.ac.ctrl.open_loop) begin
            a_fall = place({2'b00, q.ac.ev2}, q.ac.adj_a, q.ac.ctrl);
            b_fall = place({2'b00, q.ac.ev4}, q.ac.adj_b, q.ac.ctrl);
        end else begin
            a_fall = place({2'b00, q.ac.ev1, 4'h0} + {1'b0, duty_fine},
                           q.ac.adj_a, q.ac.ctrl);
            b_fall = place({2'b00, q.ac.ev3} + {1'b0, duty_fine},
                           q.ac.adj_b, q.ac.ctrl);
        end
    end

    // oversampling splits the period into 1, 2, 4 or 8 equal segments
    always_comb begin
        seg_len = ({1'b0, q.ac.period_limit} + 15'h1) >> q.ac.ctrl.oversample;
        if (seg_len == 15'h0) begin
            seg_len = 15'h1;
        end
    end

    assign wrap = q.ac.ctrl.run && (q.cnt == q.ac.period_limit);
    assign sync_hit = q.ac.ctrl.sync_en && sync_in;
    // stored value is a quarter count because it was sized for the slow compare clock
    assign samp_hit1 = q.ac.ctrl.run &&
                       ({2'b00, q.seg} == {q.ac.samp1, 2'b00});
    assign samp_hit2 = q.ac.ctrl.run &&
                       ({2'b00, q.cnt} == {q.ac.samp2, 2'b00});

    always_comb begin
        d = q;
        // register port writes land in the shadow set only, apart from the run bit
        if (reg_wr) begin
            case (reg_addr)
                A_CTRL: d.sh.ctrl = reg_wdata[CTRL_W-1:0];
                A_PERIOD: d.sh.period_limit = reg_wdata[13:0];
                A_EV1: d.sh.ev1 = reg_wdata[13:0];
                A_EV2: d.sh.ev2 = reg_wdata[17:0];
                A_EV3: d.sh.ev3 = reg_wdata[17:0];
                A_EV4: d.sh.ev4 = reg_wdata[17:0];
                A_ADJ_A: d.sh.adj_a = reg_wdata[15:0];
                A_ADJ_B: d.sh.adj_b = reg_wdata[15:0];
                A_SAMP1: d.sh.samp1 = reg_wdata[13:0];
                A_SAMP2: d.sh.samp2 = reg_wdata[13:0];
                A_PHASE: d.sh.phase = reg_wdata[13:0];
                A_SYNC: d.sh.sync_thr = reg_wdata[13:0];
                A_BLANK_A: begin
                    d.sh.blka_beg = reg_wdata[13:0];
                    d.sh.blka_end = reg_wdata[BLK_END_LSB +: 14];
                end
                A_BLANK_B: begin
                    d.sh.blkb_beg = reg_wdata[13:0];
                    d.sh.blkb_end = reg_wdata[BLK_END_LSB +: 14];
                end
                A_DEAD: d.sh.dead = reg_wdata[7:0];
                default: d.sh = d.sh;
            endcase
        end
        if (reg_rd) begin
            d.rdata = rd_mux(q.sh, reg_addr, q.cnt, pwm_a, pwm_b);
        end
        if (duty_valid) begin
            d.duty_sh = duty_in[23] ? 23'h0 : duty_in[22:0];
        end
        // run control acts at once so a stopped channel can be started
        d.ac.ctrl.run = d.sh.ctrl.run;
        // counter and segment counter
        if (!q.ac.ctrl.run || sync_hit) begin
            d.cnt = 14'h0;
            d.seg = 14'h0;
        end else if (wrap) begin
            d.cnt = 14'h0;
            d.seg = 14'h0;
        end else begin
            d.cnt = q.cnt + 14'h1;
            if ({1'b0, q.seg} == seg_len - 15'h1) begin
                d.seg = 14'h0;
            end else begin
                d.seg = q.seg + 14'h1;
            end
        end
        // compares never see a half-written set; stopped channel follows at once
        if (wrap || !q.ac.ctrl.run) begin
            d.ac = d.sh;
            d.duty_ac = q.ac.ctrl.open_loop ? q.duty_ac : q.duty_sh;
        end
        d.period_evt = wrap;
        d.sync_out = q.ac.ctrl.run && (q.cnt == q.ac.sync_thr);
        d.phase_trig = q.ac.ctrl.run && (q.cnt == q.ac.phase);
        d.adc_trig = samp_hit1 || samp_hit2;
        d.blank_a = inside_win(q.cnt, q.ac.blka_beg, q.ac.blka_end);
        d.blank_b = inside_win(q.cnt, q.ac.blkb_beg, q.ac.blkb_end);
        d.fault_out = fault_in && !q.blank_a && !q.blank_b;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '0;
            q.sh.period_limit <= PERIOD_RST;
            q.ac.period_limit <= PERIOD_RST;
            q.sh.dead <= DEAD_RST;
            q.ac.dead <= DEAD_RST;
            q.sh.ev2 <= {EVT_OFF, 4'h0};
            q.ac.ev2 <= {EVT_OFF, 4'h0};
            q.sh.ev4 <= {EVT_OFF, 4'h0};
            q.ac.ev4 <= {EVT_OFF, 4'h0};
        end else begin
            q <= d;
        end
    end

    // the fine code drives the external sixteen-phase selector at each edge
    hpp_edge u_edge_a (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cnt(q.cnt),
        .period_limit(q.ac.period_limit),
        .rise_at(a_rise),
        .fall_at(a_fall),
        .pol_low(q.ac.ctrl.pol_a_low),
        .dead(q.ac.dead),
        .other_on(on_b),
        .on(on_a),
        .pin(pwm_a),
        .fine(fine_a)
    );

    hpp_edge u_edge_b (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cnt(q.cnt),
        .period_limit(q.ac.period_limit),
        .rise_at(b_rise),
        .fall_at(b_fall),
        .pol_low(q.ac.ctrl.pol_b_low),
        .dead(q.ac.dead),
        .other_on(on_a),
        .on(on_b),
        .pin(pwm_b),
        .fine(fine_b)
    );

    assign reg_rdata = q.rdata;
    assign sync_out = q.sync_out;
    assign phase_trig = q.phase_trig;
    assign adc_trig = q.adc_trig;
    assign period_evt = q.period_evt;
    assign blank_a = q.blank_a;
    assign blank_b = q.blank_b;
    assign fault_out = q.fault_out;

    sequence s_wrap;
        q.ac.ctrl.run && (q.cnt == q.ac.period_limit) && !sync_hit;
    endsequence

    sequence s_restart;
        (q.cnt == 14'h0) ##1 (q.cnt == 14'h1 || !q.ac.ctrl.run || sync_hit);
    endsequence

    property p_wrap;
        @(posedge clk_sys) disable iff (sys_rst)
        s_wrap |=> s_restart;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not restart at period");

    property p_count;
        @(posedge clk_sys) disable iff (sys_rst)
        q.ac.ctrl.run && !sync_hit && (q.cnt < q.ac.period_limit)
            |=> q.cnt == $past(q.cnt) + 14'h1;
    endproperty
    a_count: assert property (p_count) else $error("counter did not advance");

    property p_shadow;
        @(posedge clk_sys) disable iff (sys_rst)
        q.ac.ctrl.run && $past(q.ac.ctrl.run) && $changed(q.ac.period_limit)
            |-> $past(wrap);
    endproperty
    a_shadow: assert property (p_shadow) else $error("period changed mid period");

    property p_sync_in;
        @(posedge clk_sys) disable iff (sys_rst)
        sync_hit |=> q.cnt == 14'h0;
    endproperty
    a_sync_in: assert property (p_sync_in) else $error("sync did not reset counter");

    property p_sync_out;
        @(posedge clk_sys) disable iff (sys_rst)
        q.ac.ctrl.run && (q.cnt == q.ac.sync_thr) |=> sync_out ##1 !sync_out;
    endproperty
    a_sync_out: assert property (p_sync_out) else $error("sync output missing");

    property p_phase;
        @(posedge clk_sys) disable iff (sys_rst)
        q.ac.ctrl.run && (q.cnt == q.ac.phase) |=> phase_trig;
    endproperty
    a_phase: assert property (p_phase) else $error("phase trigger missing");

    property p_sample;
        @(posedge clk_sys) disable iff (sys_rst)
        q.ac.ctrl.run && ({2'b00, q.cnt} == {q.ac.samp2, 2'b00}) |=> adc_trig;
    endproperty
    a_sample: assert property (p_sample) else $error("sample trigger missing");

    property p_blank;
        @(posedge clk_sys) disable iff (sys_rst)
        blank_a || blank_b |=> !fault_out;
    endproperty
    a_blank: assert property (p_blank) else $error("fault passed during blanking");

    property p_period_evt;
        @(posedge clk_sys) disable iff (sys_rst)
        wrap |=> period_evt ##1 !period_evt;
    endproperty
    a_period_evt: assert property (p_period_evt) else $error("period event wrong");

    property p_open_a;
        @(posedge clk_sys) disable iff (sys_rst)
        q.ac.ctrl.open_loop && !q.ac.ctrl.fine_multi_output_enable &&
            (q.ac.adj_a == 16'h0) |-> a_fall == {1'b0, q.ac.ev2[17:4], 4'h0};
    endproperty
    a_open_a: assert property (p_open_a) else $error("open loop A fall wrong");
endmodule : hpp_pwm

// *** hpp_pkg.sv ***
package hpp_pkg;
    // counter, event, adjust, duty and control widths
    localparam int CNT_W = 14;
    localparam int FINE_W = 4;
    localparam int EVT_W = 18;
    localparam int POS_W = 19;
    localparam int ADJ_W = 16;
    localparam int DUTY_W = 24;
    localparam int DUTY_FRAC = 23;
    localparam int CTRL_W = 12;
    // fine placement: sixteen clock phases, 250 ps each at the nominal fast clock
    localparam int FINE_PHASES = 16;
    localparam int FINE_STEP_PS = 250;
    localparam int ADJ_RANGE_STEPS = 32768;
    localparam int SAMPLE_SHIFT = 2;
    // register indices on the plain register port
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_PERIOD = 4'h1;
    localparam logic [3:0] A_EV1 = 4'h2;
    localparam logic [3:0] A_EV2 = 4'h3;
    localparam logic [3:0] A_EV3 = 4'h4;
    localparam logic [3:0] A_EV4 = 4'h5;
    localparam logic [3:0] A_ADJ_A = 4'h6;
    localparam logic [3:0] A_ADJ_B = 4'h7;
    localparam logic [3:0] A_SAMP1 = 4'h8;
    localparam logic [3:0] A_SAMP2 = 4'h9;
    localparam logic [3:0] A_PHASE = 4'ha;
    localparam logic [3:0] A_SYNC = 4'hb;
    localparam logic [3:0] A_BLANK_A = 4'hc;
    localparam logic [3:0] A_BLANK_B = 4'hd;
    localparam logic [3:0] A_DEAD = 4'he;
    localparam logic [3:0] A_STATUS = 4'hf;
    // field positions inside the blanking words
    localparam int BLK_END_LSB = 16;
    // reset values
    localparam logic [13:0] PERIOD_RST = 14'h00ff;
    localparam logic [7:0] DEAD_RST = 8'h04;
    localparam logic [13:0] EVT_OFF = 14'h3fff;

    typedef logic [3:0] hpp_addr_t;

    typedef struct packed {
        logic sync_en;
        logic [1:0] oversample;
        logic pol_b_low;
        logic pol_a_low;
        logic phase_clocks_enable;
        logic [2:0] fine_step_scale;
        logic fine_multi_output_enable;
        logic open_loop;
        logic run;
    } hpp_ctrl_t;

    typedef struct packed {
        hpp_ctrl_t ctrl;
        logic [13:0] period_limit;
        logic [13:0] ev1;
        logic [17:0] ev2;
        logic [17:0] ev3;
        logic [17:0] ev4;
        logic [15:0] adj_a;
        logic [15:0] adj_b;
        logic [13:0] samp1;
        logic [13:0] samp2;
        logic [13:0] phase;
        logic [13:0] sync_thr;
        logic [13:0] blka_beg;
        logic [13:0] blka_end;
        logic [13:0] blkb_beg;
        logic [13:0] blkb_end;
        logic [7:0] dead;
    } hpp_cfg_t;
endpackage : hpp_pkg

// *** hpp_edge.sv ***
module hpp_edge (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [hpp_pkg::CNT_W-1:0] cnt,
    input wire logic [hpp_pkg::CNT_W-1:0] period_limit,
    input wire logic [hpp_pkg::POS_W-1:0] rise_at,
    input wire logic [hpp_pkg::POS_W-1:0] fall_at,
    input wire logic pol_low,
    input wire logic [7:0] dead,
    input wire logic other_on,
    output logic on,
    output logic pin,
    output logic [hpp_pkg::FINE_W-1:0] fine
);
    import hpp_pkg::*;

    typedef struct packed {
        logic raw;
        logic [7:0] gap;
        logic on;
        logic pin;
        logic [3:0] fine;
    } hpp_edge_t;

    hpp_edge_t q, d;

    // an edge beyond the active period never fires, so the level is kept
    function automatic logic hit(input logic [18:0] v, input logic [13:0] c,
                                 input logic [13:0] p);
        hit = (v[18:4] <= {1'b0, p}) && (v[17:4] == c);
    endfunction : hit

    always_comb begin
        d = q;
        if (hit(rise_at, cnt, period_limit)) begin
            d.raw = 1'b1;
            d.fine = rise_at[3:0];
        end
        if (hit(fall_at, cnt, period_limit)) begin
            d.raw = 1'b0;
            d.fine = fall_at[3:0];
        end
        if (other_on) begin
            d.gap = 8'h00;
        end else if (q.gap != 8'hff) begin
            d.gap = q.gap + 8'h01;
        end
        // both sides may rise together when both gaps are already long: keep events apart
        d.on = d.raw & ~other_on & (q.gap >= dead);
        d.pin = d.on ^ pol_low;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign on = q.on;
    assign pin = q.pin;
    assign fine = q.fine;

    property p_dead_gap;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(q.on) |-> ($past(q.gap) >= $past(dead)) && !$past(other_on);
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("output rose inside dead time");

    property p_pol;
        @(posedge clk_sys) disable iff (sys_rst)
        $stable(pol_low) |-> (q.pin == (q.on ^ pol_low));
    endproperty
    a_pol: assert property (p_pol) else $error("pin polarity wrong");
endmodule : hpp_edge

// *** hpp_far_model.sv ***
module hpp_far_model (
    input wire logic clk_sys,
    input wire logic pwm_a,
    input wire logic pwm_b,
    output logic [hpp_pkg::DUTY_W-1:0] duty_in,
    output logic duty_valid,
    output logic sync_in,
    output logic fault_in,
    output int both_on
);
    timeunit 1ns;
    timeprecision 1ns;
    import hpp_pkg::*;
    initial begin
        duty_in = '0;
        duty_valid = 1'b0;
        sync_in = 1'b0;
        fault_in = 1'b0;
    end
    // shoot-through watch: a real half bridge would short here
    always @(posedge clk_sys) begin
        if (pwm_a && pwm_b) begin
            both_on <= both_on + 1;
        end
    end
    // filter keeps its last word on the bus after the strobe
    task send_duty(input logic [DUTY_W-1:0] d);
        @(posedge clk_sys);
        duty_in <= d;
        duty_valid <= 1'b1;
        @(posedge clk_sys);
        duty_valid <= 1'b0;
    endtask : send_duty
    task set_sync(input logic v);
        @(posedge clk_sys);
        sync_in <= v;
    endtask : set_sync
    // raw fault level from the power stage; blanking decides what gets through
    task set_fault(input logic v);
        @(posedge clk_sys);
        fault_in <= v;
    endtask : set_fault
endmodule : hpp_far_model

// *** tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hpp_pkg::*;
    typedef struct {hpp_addr_t a; logic [31:0] w; logic [31:0] e;} hpp_row_t;
    logic clk_sys, sys_rst, reg_wr, reg_rd, duty_valid, sync_in, fault_in;
    hpp_addr_t reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [DUTY_W-1:0] duty_in;
    logic sync_out, phase_trig, adc_trig, period_evt, pwm_a, pwm_b;
    logic blank_a, blank_b, fault_out;
    logic [FINE_W-1:0] fine_a, fine_b;
    int miscompares, checks, both_on, ca, cb, cs, cp, cd, ce, cl, cf, cg;
    time t0;
    hpp_row_t rows[8];
    logic [35:0] cfg[15];
    hpp_pwm dut_u (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .duty_in, .duty_valid, .sync_in, .fault_in, .sync_out,
        .phase_trig, .adc_trig, .period_evt, .pwm_a, .pwm_b, .fine_a, .fine_b,
        .blank_a, .blank_b, .fault_out);
    hpp_far_model far_u (.clk_sys, .pwm_a, .pwm_b, .duty_in, .duty_valid,
        .sync_in, .fault_in, .both_on);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task wrap_up;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task wr(input hpp_addr_t a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input hpp_addr_t a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask : rd
    // bounded: a stalled counter must not hang the run
    task wait_evt;
        int n;
        n = 0;
        @(posedge clk_sys);
        while (period_evt !== 1'b1) begin
            n++;
            if (n > 300) begin
                chk(32'h0, 32'h1);
                wrap_up();
            end
            @(posedge clk_sys);
        end
    endtask : wait_evt
    task cnt_win(input int n);
        {ca, cb, cs, cp, cd, ce, cl, cf, cg} = '0;
        repeat (n) begin
            @(posedge clk_sys);
            ca += int'(pwm_a);
            cb += int'(pwm_b);
            cs += int'(sync_out);
            cp += int'(phase_trig);
            cd += int'(adc_trig);
            ce += int'(period_evt);
            cl += int'(blank_a);
            cg += int'(blank_b);
            cf += int'(fault_out);
        end
    endtask : cnt_win
    // two wraps first so shadow writes have reached the active set
    task meas(input int n);
        wait_evt();
        wait_evt();
        cnt_win(n);
    endtask : meas
    initial begin
        rows = '{'{A_PERIOD, '1, 32'h3fff}, '{A_EV1, '1, 32'h3fff},
            '{A_EV2, '1, 32'h3ffff}, '{A_ADJ_A, '1, 32'hffff}, '{A_DEAD, '1, 32'hff},
            '{A_BLANK_A, '1, 32'h3fff3fff}, '{A_SAMP1, '1, 32'h3fff},
            '{A_STATUS, '1, 32'h0}};
        cfg = '{{A_PERIOD, 32'd31}, {A_EV1, 32'h2}, {A_EV2, 32'h83}, {A_EV3, 32'hc0},
            {A_EV4, 32'h105}, {A_ADJ_A, 32'h10}, {A_ADJ_B, 32'h20}, {A_SAMP1, 32'h0},
            {A_SAMP2, 32'h3ff}, {A_PHASE, 32'h7}, {A_SYNC, 32'h5},
            {A_BLANK_A, 32'ha0002}, {A_BLANK_B, 32'h180014}, {A_DEAD, 32'h1},
            {A_CTRL, 32'h47}};
        {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 4'h0, 32'h0};
        repeat (10) @(posedge clk_sys);
        chk({pwm_b, pwm_a}, 32'h0);
        sys_rst <= 1'b0;
        rd(A_PERIOD, rv);
        chk(rv, 32'hff);
        rd(A_DEAD, rv);
        chk(rv, 32'h4);
        rd(A_EV2, rv);
        chk(rv, 32'h3fff0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rv);
            chk(rv, rows[i].e);
        end
        $display("test registers done");
        // sample position is written as a quarter of the fast count
        foreach (cfg[i]) wr(cfg[i][35:32], cfg[i][31:0]);
        far_u.set_fault(1'b1);
        meas(64);
        chk(ca, 14);
        chk(cb, 12);
        chk(cs, 2);
        chk(cp, 2);
        chk(cd, 2);
        chk(ce, 2);
        chk(cl, 16);
        chk(cg, 8);
        chk(cf, 40);
        chk(fine_a, 3);
        chk(fine_b, 5);
        chk(both_on, 0);
        far_u.set_fault(1'b0);
        meas(32);
        chk(cf, 0);
        for (int i = 1; i < 4; i++) begin
            wr(A_CTRL, 32'h47 | (i << 9));
            meas(64);
            chk(cd, 2 << i);
        end
        wr(A_CTRL, 32'h57);
        meas(32);
        chk({fine_b, fine_a}, 32'h40);
        wr(A_CTRL, 32'h43);
        meas(32);
        chk({fine_b, fine_a}, 32'h0);
        wr(A_CTRL, 32'h07);
        meas(32);
        chk({fine_b, fine_a}, 32'h0);
        wr(A_CTRL, 32'h1c7);
        meas(64);
        chk(ca, 50);
        chk(cb, 52);
        wr(A_CTRL, 32'h47);
        wr(A_DEAD, 32'h8);
        meas(64);
        chk(32'(cb < 12), 32'h1);
        wr(A_DEAD, 32'h1);
        wr(A_EV4, 32'h280);
        meas(64);
        chk(cb, 64);
        chk(ca, 0);
        wr(A_EV4, 32'h105);
        $display("test open loop done");
        wr(A_CTRL, 32'h45);
        far_u.send_duty(24'h404000);
        meas(64);
        chk(ca, 34);
        chk(fine_a, 1);
        far_u.send_duty(24'h800000);
        meas(64);
        chk(ca, 2);
        far_u.send_duty(24'h404000);
        wr(A_CTRL, 32'h47);
        meas(64);
        chk(ca, 14);
        $display("test closed loop done");
        wr(A_CTRL, 32'h847);
        wait_evt();
        wait_evt();
        far_u.set_sync(1'b1);
        cnt_win(68);
        chk(ce, 0);
        far_u.set_sync(1'b0);
        wr(A_CTRL, 32'h47);
        wait_evt();
        wait_evt();
        far_u.set_sync(1'b1);
        cnt_win(64);
        chk(ce, 2);
        far_u.set_sync(1'b0);
        $display("test sync done");
        wait_evt();
        t0 = $time;
        wr(A_PERIOD, 32'd63);
        wait_evt();
        chk(32'(($time - t0) / 10), 32'd32);
        t0 = $time;
        wait_evt();
        chk(32'(($time - t0) / 10), 32'd64);
        $display("test shadow period done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({pwm_b, pwm_a, period_evt}, 32'h0);
        sys_rst <= 1'b0;
        rd(A_PERIOD, rv);
        chk(rv, 32'hff);
        $display("test reset done");
        wrap_up();
    end
endmodule : tb_top
